// ---- shared/rpf_pkg.sv ----
// Constants, types and carriers for the radio packet framer.
// Behaviour
// - Fields go out in fixed packet order.
// - Coded modes add indicator and termination fields.
// - Static extension sits between payload and checksum.
// - Preamble goes out least significant bit first.
// - One byte preamble 0xaa or 0x55.
// - Two byte preamble 0xaaaa or 0x5555.
// - Coded preamble is ten 0x3c bytes.
// - Low rate preamble is four zero bytes.
// - Memory holds only headers, length, payload and static extension.
// - Address, payload low byte first; checksum high first.
// - Address bits always least significant first.
// - Checksum bits always most significant first.
// - Header, length, payload bit order is configurable.
// - Narrow fields use low bits of byte.
// - Zero width fields absent; others one byte.
// - Headers, length and payload capped at 258.
// - Address is base part plus prefix byte.
// - Short base drops least significant bytes first.
// - Bit counter raises event at target count.
// - Checksum skips preamble, coding indicator and termination, optionally the address.
package rpf_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int BIT_NS_1M     = 1000;
  localparam int BIT_NS_2M     = 500;
  localparam int BIT_NS_125K   = 8000;
  localparam int BIT_NS_500K   = 2000;
  localparam int BIT_NS_250K   = 4000;
  localparam logic [9:0] BIT_CYC_1M   = 10'(BIT_NS_1M / CLK_PERIOD_NS);
  localparam logic [9:0] BIT_CYC_2M   = 10'(BIT_NS_2M / CLK_PERIOD_NS);
  localparam logic [9:0] BIT_CYC_125K = 10'(BIT_NS_125K / CLK_PERIOD_NS);
  localparam logic [9:0] BIT_CYC_500K = 10'(BIT_NS_500K / CLK_PERIOD_NS);
  localparam logic [9:0] BIT_CYC_250K = 10'(BIT_NS_250K / CLK_PERIOD_NS);

  typedef enum logic [2:0] {
    RPF_LOW_ENERGY_ONE_MEGABIT_MODE   = 3'h0,
    RPF_LOW_ENERGY_TWO_MEGABIT_MODE   = 3'h1,
    RPF_PROPRIETARY_ONE_MEGABIT_MODE  = 3'h2,
    RPF_PROPRIETARY_TWO_MEGABIT_MODE  = 3'h3,
    RPF_LONG_RANGE_CODED_SLOW_MODE    = 3'h4,
    RPF_LONG_RANGE_CODED_FAST_MODE    = 3'h5,
    RPF_LOW_RATE_WPAN_MODE            = 3'h6
  } rpf_mode_t;

  typedef enum logic [3:0] {
    RPF_IDLE                     = 4'h0,
    RPF_PREAMBLE_FIELD           = 4'h1,
    RPF_ADDRESS_FIELD            = 4'h2,
    RPF_CODING_INDICATOR_FIELD   = 4'h3,
    RPF_FIRST_TERMINATION_FIELD  = 4'h4,
    RPF_FIRST_HEADER_FIELD       = 4'h5,
    RPF_LENGTH_FIELD             = 4'h6,
    RPF_SECOND_HEADER_FIELD      = 4'h7,
    RPF_PAYLOAD_FIELD            = 4'h8,
    RPF_STATIC_EXTENSION_FIELD   = 4'h9,
    RPF_CHECKSUM_FIELD           = 4'ha,
    RPF_SECOND_TERMINATION_FIELD = 4'hb
  } rpf_field_t;

  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_MODE    = 8'h04;
  localparam logic [7:0] REG_CFG0    = 8'h08;
  localparam logic [7:0] REG_CFG1    = 8'h0c;
  localparam logic [7:0] REG_BASE    = 8'h10;
  localparam logic [7:0] REG_PREFIX  = 8'h14;
  localparam logic [7:0] REG_POLY    = 8'h18;
  localparam logic [7:0] REG_INIT    = 8'h1c;
  localparam logic [7:0] REG_PKTPTR  = 8'h20;
  localparam logic [7:0] REG_BITTGT  = 8'h24;
  localparam logic [7:0] REG_STATUS  = 8'h28;
  localparam logic [7:0] REG_BITCNT  = 8'h2c;

  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_STOP_BIT  = 1;
  localparam int ST_BUSY_BIT    = 0;
  localparam int ST_DONE_BIT    = 1;
  localparam int ST_MATCH_BIT   = 2;
  localparam int CFG0_H1W_LSB   = 0;
  localparam int CFG0_LFW_LSB   = 4;
  localparam int CFG0_H2W_LSB   = 8;
  localparam int CFG0_PLEN_BIT  = 12;
  localparam int CFG1_MAXLEN_LSB  = 0;
  localparam int CFG1_STATLEN_LSB = 8;
  localparam int CFG1_BALEN_LSB   = 16;
  localparam int CFG1_ORDER_BIT   = 20;
  localparam int CFG1_SKIPADR_BIT = 21;
  localparam int CFG1_CRCLEN_LSB  = 24;

  localparam logic [31:0] CFG0_MASK = 32'h0000_1fff;
  localparam logic [31:0] CFG1_MASK = 32'h0337_ffff;
  localparam logic [31:0] CFG0_RST  = 32'h0000_0000;
  localparam logic [31:0] CFG1_RST  = 32'h0304_0000;

  localparam logic [7:0] PRE_ADDR_EVEN = 8'haa;
  localparam logic [7:0] PRE_ADDR_ODD  = 8'h55;
  localparam logic [7:0] PRE_CODED     = 8'h3c;
  localparam logic [7:0] PRE_WPAN      = 8'h00;
  localparam logic [8:0] PRE_CODED_REPS = 9'h00a;
  localparam logic [8:0] PRE_WPAN_REPS  = 9'h004;
  localparam logic [5:0] CODE_IND_BITS  = 6'h02;
  localparam logic [5:0] TERM_BITS      = 6'h03;
  localparam logic [1:0] CODE_IND_SLOW  = 2'h0;
  localparam logic [1:0] CODE_IND_FAST  = 2'h1;
  localparam logic [8:0] MAX_FRAME_BYTES = 9'h102;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } rpf_bus_req_t;

  typedef struct packed {
    logic        rd;
    logic [15:0] addr;
  } rpf_mem_req_t;

  typedef struct packed {
    logic bit_val;
    logic vld;
    logic active;
  } rpf_tx_t;

  typedef struct packed {
    logic bit_match;
    logic pkt_done;
  } rpf_evt_t;
endpackage

// ---- rtl/rpf_framer.sv ----
// Transmit packet assembler: memory bytes and settings to an on-air bit stream.
`timescale 1ns/1ps
module rpf_framer
  import rpf_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire rpf_bus_req_t bus,
  output logic [31:0]       rdata,
  output rpf_mem_req_t      mem,
  input  wire logic [7:0]   mem_rdata,
  output rpf_tx_t           tx,
  output rpf_evt_t          evt
);

  typedef struct packed {
    rpf_mode_t    mode;
    logic [31:0]  cfg0;
    logic [31:0]  cfg1;
    logic [31:0]  base;
    logic [7:0]   prefix;
    logic [23:0]  poly;
    logic [23:0]  init;
    logic [15:0]  pktptr;
    logic [15:0]  bittgt;
    logic         done_st;
    logic         match_st;
    rpf_field_t   field;
    logic [39:0]  sh;
    logic [5:0]   bits;
    logic [8:0]   reps;
    logic [7:0]   pat;
    logic [3:0]   w;
    logic         msbf;
    logic         ld;
    logic [23:0]  crc;
    logic [15:0]  bitcnt;
    logic [15:0]  ptr;
    logic [8:0]   paylen;
    logic [9:0]   div;
    logic [31:0]  rdata;
    rpf_mem_req_t mem;
    rpf_tx_t      tx;
    rpf_evt_t     evt;
  } rpf_state_t;

  rpf_state_t s;
  rpf_state_t n;

  function automatic logic [9:0] bit_period(input rpf_mode_t m);
    unique case (m)
      RPF_LOW_ENERGY_TWO_MEGABIT_MODE,
      RPF_PROPRIETARY_TWO_MEGABIT_MODE: bit_period = BIT_CYC_2M;
      RPF_LONG_RANGE_CODED_SLOW_MODE:   bit_period = BIT_CYC_125K;
      RPF_LONG_RANGE_CODED_FAST_MODE:   bit_period = BIT_CYC_500K;
      RPF_LOW_RATE_WPAN_MODE:           bit_period = BIT_CYC_250K;
      default:                          bit_period = BIT_CYC_1M;
    endcase
  endfunction

  function automatic logic coded(input rpf_mode_t m);
    coded = (m == RPF_LONG_RANGE_CODED_SLOW_MODE) || (m == RPF_LONG_RANGE_CODED_FAST_MODE);
  endfunction

  function automatic logic [3:0] h1w(input logic [31:0] c0);
    h1w = c0[CFG0_H1W_LSB +: 4];
  endfunction

  function automatic logic [3:0] lfw(input logic [31:0] c0);
    lfw = c0[CFG0_LFW_LSB +: 4];
  endfunction

  function automatic logic [3:0] h2w(input logic [31:0] c0);
    h2w = c0[CFG0_H2W_LSB +: 4];
  endfunction

  function automatic logic [1:0] crclen(input logic [31:0] c1);
    crclen = c1[CFG1_CRCLEN_LSB +: 2];
  endfunction

  // Base is kept from its top byte down, prefix lands just above the kept bytes.
  function automatic logic [39:0] addr_word(input logic [31:0] b, input logic [7:0] p,
                                            input logic [2:0] blen);
    logic [2:0] nb;
    logic [5:0] drop;
    nb = (blen > 3'h4) ? 3'h4 : blen;
    drop = 6'({3'h4 - nb, 3'h0});
    addr_word = ({8'h00, b} >> drop) | ({p, 32'h0} >> drop);
  endfunction

  function automatic logic [23:0] left_align(input logic [23:0] v, input logic [1:0] len);
    left_align = v << (5'd24 - 5'({len, 3'h0}));
  endfunction

  // Headers, length and payload together never pass the frame cap.
  function automatic logic [8:0] clamp_len(input logic [8:0] v, input logic [31:0] c0,
                                           input logic [31:0] c1);
    logic [8:0] hb;
    logic [8:0] lim;
    hb = 9'(h1w(c0) != 4'h0) + 9'(lfw(c0) != 4'h0) + 9'(h2w(c0) != 4'h0);
    lim = MAX_FRAME_BYTES - hb;
    clamp_len = v;
    if (clamp_len > 9'(c1[CFG1_MAXLEN_LSB +: 8])) clamp_len = 9'(c1[CFG1_MAXLEN_LSB +: 8]);
    if (clamp_len > lim) clamp_len = lim;
  endfunction

  function automatic rpf_field_t succ(input rpf_field_t f, input logic lr);
    unique case (f)
      RPF_PREAMBLE_FIELD:          succ = RPF_ADDRESS_FIELD;
      RPF_ADDRESS_FIELD:           succ = lr ? RPF_CODING_INDICATOR_FIELD
                                             : RPF_FIRST_HEADER_FIELD;
      RPF_CODING_INDICATOR_FIELD:  succ = RPF_FIRST_TERMINATION_FIELD;
      RPF_FIRST_TERMINATION_FIELD: succ = RPF_FIRST_HEADER_FIELD;
      RPF_FIRST_HEADER_FIELD:      succ = RPF_LENGTH_FIELD;
      RPF_LENGTH_FIELD:            succ = RPF_SECOND_HEADER_FIELD;
      RPF_SECOND_HEADER_FIELD:     succ = RPF_PAYLOAD_FIELD;
      RPF_PAYLOAD_FIELD:           succ = RPF_STATIC_EXTENSION_FIELD;
      RPF_STATIC_EXTENSION_FIELD:  succ = RPF_CHECKSUM_FIELD;
      RPF_CHECKSUM_FIELD:          succ = lr ? RPF_SECOND_TERMINATION_FIELD : RPF_IDLE;
      default:                     succ = RPF_IDLE;
    endcase
  endfunction

  // Next field that actually has bits on air; zero sized ones are skipped.
  function automatic rpf_field_t next_field(input rpf_field_t f, input rpf_state_t st);
    logic empty;
    next_field = succ(f, coded(st.mode));
    for (int i = 0; i < 6; i++) begin
      unique case (next_field)
        RPF_FIRST_HEADER_FIELD:     empty = h1w(st.cfg0) == 4'h0;
        RPF_LENGTH_FIELD:           empty = lfw(st.cfg0) == 4'h0;
        RPF_SECOND_HEADER_FIELD:    empty = h2w(st.cfg0) == 4'h0;
        RPF_PAYLOAD_FIELD:          empty = st.paylen == 9'h000;
        RPF_STATIC_EXTENSION_FIELD: empty = st.cfg1[CFG1_STATLEN_LSB +: 8] == 8'h00;
        RPF_CHECKSUM_FIELD:         empty = crclen(st.cfg1) == 2'h0;
        default:                    empty = 1'b0;
      endcase
      if (empty) next_field = succ(next_field, coded(st.mode));
    end
  endfunction

  logic        tick;
  logic        bitv;
  logic        fb;
  logic [7:0]  mbyte;
  logic [39:0] aw;
  rpf_field_t  nf;

  always_comb begin
    n = s;
    n.tx.vld = 1'b0;
    n.mem.rd = 1'b0;
    n.evt = '0;
    n.ld = 1'b0;
    n.rdata = '0;
    tick = (s.div == 10'h000);
    bitv = 1'b0;
    fb = 1'b0;
    mbyte = '0;
    nf = RPF_IDLE;
    aw = addr_word(s.base, s.prefix, s.cfg1[CFG1_BALEN_LSB +: 3]);

    if (bus.rd) begin
      case (bus.addr)
        REG_MODE:   n.rdata = {29'h0, s.mode};
        REG_CFG0:   n.rdata = s.cfg0;
        REG_CFG1:   n.rdata = s.cfg1;
        REG_BASE:   n.rdata = s.base;
        REG_PREFIX: n.rdata = {24'h0, s.prefix};
        REG_POLY:   n.rdata = {8'h0, s.poly};
        REG_INIT:   n.rdata = {8'h0, s.init};
        REG_PKTPTR: n.rdata = {16'h0, s.pktptr};
        REG_BITTGT: n.rdata = {16'h0, s.bittgt};
        REG_STATUS: n.rdata = {29'h0, s.match_st, s.done_st, s.field != RPF_IDLE};
        REG_BITCNT: n.rdata = {16'h0, s.bitcnt};
        default:    n.rdata = '0;
      endcase
    end
    if (bus.wr) begin
      case (bus.addr)
        REG_MODE:   n.mode = rpf_mode_t'(bus.wdata[2:0]);
        REG_CFG0:   n.cfg0 = bus.wdata & CFG0_MASK;
        REG_CFG1:   n.cfg1 = bus.wdata & CFG1_MASK;
        REG_BASE:   n.base = bus.wdata;
        REG_PREFIX: n.prefix = bus.wdata[7:0];
        REG_POLY:   n.poly = bus.wdata[23:0];
        REG_INIT:   n.init = bus.wdata[23:0];
        REG_PKTPTR: n.pktptr = bus.wdata[15:0];
        REG_BITTGT: n.bittgt = bus.wdata[15:0];
        REG_STATUS: begin
          if (bus.wdata[ST_DONE_BIT]) n.done_st = 1'b0;
          if (bus.wdata[ST_MATCH_BIT]) n.match_st = 1'b0;
        end
        default: ;
      endcase
    end

    // The fetched byte stands while the registered fetch strobe does, so it is taken then.
    if (s.ld) begin
      mbyte = mem_rdata & 8'(8'hff >> (4'h8 - s.w));
      n.sh = s.msbf ? {8'(mbyte << (4'h8 - s.w)), 32'h0} : {32'h0, mbyte};
      if (s.field == RPF_LENGTH_FIELD) begin
        n.paylen = clamp_len({1'b0, mbyte}, s.cfg0, s.cfg1);
      end
    end

    if (s.field == RPF_IDLE) begin
      n.div = bit_period(s.mode) - 10'h001;
    end else begin
      n.div = tick ? bit_period(s.mode) - 10'h001 : s.div - 10'h001;
    end

    if (s.field != RPF_IDLE && tick) begin
      bitv = s.msbf ? s.sh[39] : s.sh[0];
      n.tx.vld = 1'b1;
      n.tx.bit_val = bitv;
      n.sh = s.msbf ? {s.sh[38:0], 1'b0} : {1'b0, s.sh[39:1]};
      n.bits = s.bits - 6'h01;
      if ((s.field >= RPF_FIRST_HEADER_FIELD && s.field <= RPF_STATIC_EXTENSION_FIELD) ||
          (s.field == RPF_ADDRESS_FIELD && !s.cfg1[CFG1_SKIPADR_BIT])) begin
        fb = s.crc[23] ^ bitv;
        n.crc = {s.crc[22:0], 1'b0} ^ (fb ? left_align(s.poly, crclen(s.cfg1)) : 24'h0);
      end
      if (s.field != RPF_PREAMBLE_FIELD && s.field != RPF_ADDRESS_FIELD) begin
        n.bitcnt = s.bitcnt + 16'h0001;
        if (n.bitcnt == s.bittgt) begin
          n.evt.bit_match = 1'b1;
          n.match_st = 1'b1;
        end
      end
      if (s.bits == 6'h01) begin
        if (s.reps > 9'h001) begin
          n.reps = s.reps - 9'h001;
          n.bits = 6'h08;
          if (s.field == RPF_PREAMBLE_FIELD) begin
            n.sh = {32'h0, s.pat};
          end else begin
            n.mem.rd = 1'b1;
            n.mem.addr = s.ptr;
            n.ptr = s.ptr + 16'h0001;
            n.ld = 1'b1;
          end
        end else begin
          nf = next_field(s.field, s);
          n.field = nf;
          n.reps = 9'h001;
          n.msbf = 1'b0;
          unique case (nf)
            RPF_ADDRESS_FIELD: begin
              n.sh = aw;
              n.bits = 6'({s.cfg1[CFG1_BALEN_LSB +: 3] > 3'h4 ? 3'h4
                            : s.cfg1[CFG1_BALEN_LSB +: 3], 3'h0}) + 6'h08;
            end
            RPF_CODING_INDICATOR_FIELD: begin
              n.sh = {38'h0, (s.mode == RPF_LONG_RANGE_CODED_SLOW_MODE) ? CODE_IND_SLOW
                                                                       : CODE_IND_FAST};
              n.bits = CODE_IND_BITS;
            end
            RPF_FIRST_TERMINATION_FIELD, RPF_SECOND_TERMINATION_FIELD: begin
              n.sh = '0;
              n.bits = TERM_BITS;
            end
            RPF_FIRST_HEADER_FIELD, RPF_LENGTH_FIELD, RPF_SECOND_HEADER_FIELD,
            RPF_PAYLOAD_FIELD, RPF_STATIC_EXTENSION_FIELD: begin
              n.msbf = s.cfg1[CFG1_ORDER_BIT];
              n.w = (nf == RPF_FIRST_HEADER_FIELD) ? h1w(s.cfg0) :
                    (nf == RPF_LENGTH_FIELD)       ? lfw(s.cfg0) :
                    (nf == RPF_SECOND_HEADER_FIELD) ? h2w(s.cfg0) : 4'h8;
              n.bits = 6'(n.w);
              if (nf == RPF_PAYLOAD_FIELD) n.reps = s.paylen;
              if (nf == RPF_STATIC_EXTENSION_FIELD) n.reps = 9'(s.cfg1[CFG1_STATLEN_LSB +: 8]);
              n.mem.rd = 1'b1;
              n.mem.addr = s.ptr;
              n.ptr = s.ptr + 16'h0001;
              n.ld = 1'b1;
            end
            RPF_CHECKSUM_FIELD: begin
              n.msbf = 1'b1;
              n.sh = {n.crc, 16'h0};
              n.bits = 6'({crclen(s.cfg1), 3'h0});
            end
            default: begin
              n.field = RPF_IDLE;
              n.evt.pkt_done = 1'b1;
              n.done_st = 1'b1;
            end
          endcase
        end
      end
    end

    if (bus.wr && bus.addr == REG_CTRL) begin
      if (bus.wdata[CTRL_STOP_BIT]) begin
        n.field = RPF_IDLE;
        n.ld = 1'b0;
      end else if (bus.wdata[CTRL_START_BIT] && s.field == RPF_IDLE) begin
        n.field = RPF_PREAMBLE_FIELD;
        n.bits = 6'h08;
        n.msbf = 1'b0;
        n.ptr = s.pktptr;
        n.bitcnt = '0;
        n.crc = left_align(s.init, crclen(s.cfg1));
        n.paylen = clamp_len(9'(s.cfg1[CFG1_MAXLEN_LSB +: 8]), s.cfg0, s.cfg1);
        if (coded(s.mode)) begin
          n.pat = PRE_CODED;
          n.reps = PRE_CODED_REPS;
        end else if (s.mode == RPF_LOW_RATE_WPAN_MODE) begin
          n.pat = PRE_WPAN;
          n.reps = PRE_WPAN_REPS;
        end else begin
          n.pat = aw[0] ? PRE_ADDR_ODD : PRE_ADDR_EVEN;
          n.reps = s.cfg0[CFG0_PLEN_BIT] ? 9'h002 : 9'h001;
        end
        n.sh = {32'h0, n.pat};
      end
    end
    n.tx.active = (n.field != RPF_IDLE);
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s <= '0;
      s.cfg0 <= CFG0_RST;
      s.cfg1 <= CFG1_RST;
    end else begin
      s <= n;
    end
  end

  assign rdata = s.rdata;
  assign mem = s.mem;
  assign tx = s.tx;
  assign evt = s.evt;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence seq_start;
    bus.wr && bus.addr == REG_CTRL && bus.wdata[CTRL_START_BIT] &&
      !bus.wdata[CTRL_STOP_BIT] && s.field == RPF_IDLE;
  endsequence

  sequence seq_tick(rpf_field_t f);
    s.field == f && s.div == 10'h000 && !(bus.wr && bus.addr == REG_CTRL);
  endsequence

  a_coded_preamble: assert property (seq_start ##0 coded(s.mode) |=>
      s.reps == PRE_CODED_REPS && s.pat == PRE_CODED)
    else $error("coded preamble not ten 0x3c bytes");
  a_wpan_preamble: assert property (seq_start ##0 s.mode == RPF_LOW_RATE_WPAN_MODE |=>
      s.reps == PRE_WPAN_REPS && s.pat == PRE_WPAN)
    else $error("low rate preamble not four zero bytes");
  a_short_preamble: assert property (seq_start ##0 !coded(s.mode) &&
      s.mode != RPF_LOW_RATE_WPAN_MODE |=> s.pat == (s.sh[0] ? PRE_ADDR_ODD : PRE_ADDR_EVEN)
      && s.pat != $past(aw[0] ? PRE_ADDR_EVEN : PRE_ADDR_ODD))
    else $error("preamble pattern does not follow first address bit");
  a_pre_lsb_out: assert property (seq_tick(RPF_PREAMBLE_FIELD) |=>
      tx.vld && tx.bit_val == $past(s.sh[0]))
    else $error("preamble bit not least significant first");
  a_addr_lsb_out: assert property (seq_tick(RPF_ADDRESS_FIELD) |=>
      tx.vld && tx.bit_val == $past(s.sh[0]))
    else $error("address bit not least significant first");
  a_crc_msb_out: assert property (seq_tick(RPF_CHECKSUM_FIELD) |=>
      tx.vld && tx.bit_val == $past(s.sh[39]))
    else $error("checksum bit not most significant first");
  a_payload_order: assert property (s.field == RPF_PAYLOAD_FIELD &&
      $changed(s.field) == 1'b0 ##1 $changed(s.field) |-> s.field inside
      {RPF_STATIC_EXTENSION_FIELD, RPF_CHECKSUM_FIELD, RPF_SECOND_TERMINATION_FIELD, RPF_IDLE})
    else $error("field after payload out of order");
  a_coded_fields: assert property (s.field inside {RPF_CODING_INDICATOR_FIELD,
      RPF_FIRST_TERMINATION_FIELD, RPF_SECOND_TERMINATION_FIELD} |-> coded(s.mode))
    else $error("coded fields outside coded mode");
  a_zero_width_skip: assert property (s.field == RPF_FIRST_HEADER_FIELD |->
      h1w(s.cfg0) != 4'h0)
    else $error("zero width header sent");
  a_len_limit: assert property (s.tx.active |-> s.paylen + 9'(h1w(s.cfg0) != 4'h0) +
      9'(lfw(s.cfg0) != 4'h0) + 9'(h2w(s.cfg0) != 4'h0) <= MAX_FRAME_BYTES)
    else $error("frame length above cap");
  a_fetch_order: assert property (!mem.rd && s.ptr != s.pktptr ##1 mem.rd |->
      mem.addr == $past(mem.addr) + 16'h0001)
    else $error("memory fetch not ascending");
  a_bit_match: assert property (evt.bit_match |-> s.bitcnt == s.bittgt && s.match_st)
    else $error("bit counter event at wrong count");
endmodule

// ---- dv/rpf_mem_model.sv ----
// Memory partner that answers framer byte fetches in the cycle of the strobe.
`timescale 1ns/1ps
module rpf_mem_model
  import rpf_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire rpf_mem_req_t mem,
  output logic [7:0]        mem_rdata
);
  logic [7:0] ram [0:255];
  logic [7:0] last_r;
  // The byte stands only while the strobe does; elsewhere the inverse of the last byte shows,
  // so a sample taken in any other cycle fails.
  assign mem_rdata = mem.rd ? ram[mem.addr[7:0]] : ~last_r;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      last_r <= 8'h00;
    end else if (mem.rd) begin
      last_r <= ram[mem.addr[7:0]];
    end
  end
endmodule

// ---- dv/test_rpf_framer.sv ----
// Self-checking bench for the radio packet framer transmit path.
`timescale 1ns/1ps
module test_rpf_framer import rpf_pkg::*; ;
  logic         clk = 1'b0;
  logic         nrst = 1'b0;
  rpf_bus_req_t bus = '0;
  logic [31:0]  rdata;
  rpf_mem_req_t mem;
  logic [7:0]   mem_rdata;
  rpf_tx_t      tx;
  rpf_evt_t     evt;
  int           miscompares = 0;
  int           samples_checked = 0;
  int           fetches;
  int           match_at;
  localparam logic [23:0] CRC_POLY = 24'h00065b;
  localparam logic [23:0] CRC_INIT = 24'h555555;
  logic [15:0]  exp_addr;
  logic         exp_q[$];
  logic         got_q[$];
  always #5 clk = ~clk;
  rpf_framer i_dut (.clk(clk), .nrst(nrst), .bus(bus), .rdata(rdata), .mem(mem),
                    .mem_rdata(mem_rdata), .tx(tx), .evt(evt));
  rpf_mem_model i_mem (.clk(clk), .nrst(nrst), .mem(mem), .mem_rdata(mem_rdata));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  always @(posedge clk) begin
    if (tx.vld === 1'b1) got_q.push_back(tx.bit_val);
    if (evt.bit_match === 1'b1) match_at = got_q.size();
    if (mem.rd === 1'b1) begin
      chk("fetch address", {16'h0, mem.addr}, {16'h0, exp_addr});
      exp_addr++;
      fetches++;
    end
  end
  task automatic stop_test();
    $display("mismatches %0d of %0d checks", miscompares, samples_checked);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge clk);
    bus.rd <= 1'b0;
    @(negedge clk);
    chk(nm, rdata, e);
  endtask
  task automatic put(input logic [31:0] v, input int n, input bit msb);
    for (int i = 0; i < n; i++) exp_q.push_back(v[msb ? n - 1 - i : i]);
  endtask
  // Builds the expected bit stream from the settings and memory, then sends one frame.
  task automatic frame(input logic [2:0] md, input logic [12:0] c0, input logic [31:0] c1,
                       input logic [31:0] base, input logic [7:0] pfx);
    int   bal;
    int   p;
    int   cnt;
    int   n;
    int   k;
    int   a0;
    int   a1;
    int   ln;
    logic [23:0] c;
    logic first;
    bal = (c1[18:16] > 4) ? 4 : int'(c1[18:16]);
    p = 16;
    cnt = c1[7:0];
    exp_q.delete();
    first = base[32 - 8 * bal];
    case (md)
      3'h4, 3'h5: repeat (10) put(32'(PRE_CODED), 8, 0);
      3'h6: put(32'h0, 32, 0);
      default: put(first ? 32'h5555 : 32'haaaa, (md == 3'h1 && c0[12]) ? 16 : 8, 0);
    endcase
    a0 = exp_q.size();
    for (k = 4 - bal; k < 4; k++) put(32'(base[8 * k +: 8]), 8, 0);
    put(32'(pfx), 8, 0);
    a1 = exp_q.size();
    if (md[2:1] == 2'b10) put(md[0] ? 32'(CODE_IND_FAST) : 32'(CODE_IND_SLOW), 5, 0);
    if (c0[3:0] > 0) put(32'(i_mem.ram[p++]), c0[3:0], c1[20]);
    if (c0[7:4] > 0) begin
      n = i_mem.ram[p] & ((1 << c0[7:4]) - 1);
      if (n < cnt) cnt = n;
      put(32'(i_mem.ram[p++]), c0[7:4], c1[20]);
    end
    if (c0[11:8] > 0) put(32'(i_mem.ram[p++]), c0[11:8], c1[20]);
    repeat (cnt + c1[15:8]) put(32'(i_mem.ram[p++]), 8, c1[20]);
    // Reference checksum: a plain register of ln bits fed with the covered on-air bits.
    ln = 8 * int'(c1[25:24]);
    c = CRC_INIT & 24'((1 << ln) - 1);
    for (k = c1[21] ? a1 : a0; ln > 0 && k < exp_q.size(); k++) begin
      if (md[2:1] != 2'b10 || k < a1 || k >= a1 + 5) begin
        c = ((c << 1) ^ ((c[ln - 1] ^ exp_q[k]) ? CRC_POLY : 24'h0)) & 24'((1 << ln) - 1);
      end
    end
    if (ln > 0) put(32'(c), ln, 1);
    if (md[2:1] == 2'b10) put(32'h0, 3, 0);
    wr(REG_MODE, 32'(md));
    wr(REG_CFG0, 32'(c0));
    wr(REG_CFG1, c1);
    wr(REG_BASE, base);
    wr(REG_PREFIX, 32'(pfx));
    wr(REG_PKTPTR, 32'h10);
    got_q.delete();
    fetches = 0;
    match_at = 0;
    exp_addr = 16'h0010;
    wr(REG_CTRL, 32'h1);
    @(negedge clk);
    chk("active at start", 32'(tx.active), 32'h1);
    for (k = 0; k < 40000 && evt.pkt_done !== 1'b1; k++) @(negedge clk);
    if (k == 40000) begin
      chk("frame end", 32'h0, 32'h1);
      stop_test();
    end
    chk("active at end", 32'(tx.active), 32'h0);
    rchk("status", REG_STATUS, 32'h6);
    wr(REG_STATUS, 32'h6);
    rchk("status cleared", REG_STATUS, 32'h0);
    rchk("cfg1 readback", REG_CFG1, c1 & CFG1_MASK);
    rchk("bits counted", REG_BITCNT, 32'(exp_q.size() - a1));
    chk("match position", 32'(match_at), 32'(a1 + 5));
    chk("bit count", 32'(got_q.size()), 32'(exp_q.size()));
    n = -1;
    foreach (exp_q[i]) if (n < 0 && (i >= got_q.size() || got_q[i] !== exp_q[i])) n = i;
    chk("first wrong bit", 32'(n), 32'hffff_ffff);
    chk("fetch count", 32'(fetches), 32'(p - 16));
  endtask
  initial begin
    for (int i = 0; i < 256; i++) i_mem.ram[i] = 8'(i * 37 + 5);
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    rchk("cfg1 reset", REG_CFG1, CFG1_RST);
    rchk("status reset", REG_STATUS, 32'h0);
    rchk("unmapped read", 8'h30, 32'h0);
    wr(REG_BITTGT, 32'h5);
    wr(REG_POLY, 32'(CRC_POLY));
    wr(REG_INIT, 32'(CRC_INIT));
    // Short payload limits keep the slow modes inside the run budget.
    frame(3'h0, 13'h0388, 32'h0004_0103, 32'h1234_5670, 8'h9e);
    frame(3'h1, 13'h1064, 32'h0312_0002, 32'h3c81_0000, 8'hc4);
    frame(3'h2, 13'h0008, 32'h0003_0001, 32'h5678_9a00, 8'h21);
    frame(3'h3, 13'h0020, 32'h0234_0004, 32'h0bad_f00d, 8'h7b);
    frame(3'h5, 13'h0008, 32'h0102_0000, 32'h4d1e_0000, 8'h35);
    frame(3'h6, 13'h0005, 32'h0002_0001, 32'h6a2c_0000, 8'he8);
    // Start and stop in one write: stop wins and the frame ends with no done flag.
    wr(REG_CTRL, 32'h1);
    repeat (150) @(posedge clk);
    wr(REG_CTRL, 32'h3);
    @(negedge clk);
    chk("active after stop", 32'(tx.active), 32'h0);
    rchk("status after stop", REG_STATUS, 32'h0);
    stop_test();
  end
endmodule
